// [dv/stpcfg_core_tb_top.sv]
// self-checking bench for the stepper config/status bank
`timescale 1ns/10ps
`default_nettype none
module stpcfg_core_tb_top;
  import stpcfg_pkg::*;
  logic clk, reset, step_in, ok, rd_valid, step_adv, step_pol, code_rsv;
  stpcfg_req_t reg_req;
  stpcfg_fault_t fault_in;
  stpcfg_mode_t step_res;
  logic [6:0] position;
  logic [7:0] rd_data, d, slope_vus;
  logic [4:0] cur_code;
  logic [9:0] peak, last_peak;
  logic [1:0] slope_code;
  logic [9:0] slope_tab [4] = '{10'h096, 10'h064, 10'h032, 10'h019};
  int fail_count = 0;
  int n_compared = 0;
  int hi, lo;
  stpcfg_core stpcfg_core_i (.CLK(clk), .RESET(reset), .REG_REQ(reg_req), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .FAULT_IN(fault_in), .TRANSLATOR_POSITION(position),
    .STEP_PULSE_INPUT(step_in), .STEP_ADVANCE(step_adv), .STEP_POLARITY(step_pol),
    .COIL_CURRENT_CODE(cur_code), .PEAK_COIL_CURRENT(peak), .SLOPE_CODE(slope_code),
    .SLOPE_VUS(slope_vus), .STEP_RESOLUTION(step_res), .STEP_CODE_RESERVED(code_rsv));
  stpcfg_host_model stpcfg_host_model_i (.CLK(clk), .REG_REQ(reg_req), .RD_DATA(rd_data),
    .RD_VALID(rd_valid));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] par(input logic [6:0] v);
    return {^v, v};
  endfunction : par
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    stpcfg_host_model_i.read_reg(a, d, ok);
    chk({9'h000, ok}, 10'h001, "read valid");
    chk({2'h0, d}, {2'h0, exp}, "read data");
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  // faults and position change at a rising edge, then settle two edges
  task automatic set_in(input stpcfg_fault_t f, input logic [6:0] p);
    @(posedge clk);
    fault_in <= f;
    position <= p;
    cyc(2);
  endtask : set_in
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    reset = 1'b1;
    step_in = 1'b0;
    fault_in = '0;
    position = 7'h00;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) rd(8'(a), 8'h00);
    chk(peak, 10'h00F, "reset peak");
    chk({2'h0, slope_vus}, 10'h096, "reset slope");
    stpcfg_host_model_i.write_reg(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    stpcfg_host_model_i.write_reg(8'h02, 8'hA5);
    rd(8'h02, 8'hA5);
    $display("test reset and access done");
    last_peak = 10'h000;
    for (int c = 0; c < 32; c++) begin
      stpcfg_host_model_i.write_reg(8'h01, 8'(c));
      cyc(1);
      chk({5'h00, cur_code}, 10'(c), "current code");
      chk({9'h000, peak > last_peak}, 10'h001, "peak rises");
      last_peak = peak;
    end
    chk(peak, 10'h320, "peak max");
    for (int s = 0; s < 4; s++) begin
      stpcfg_host_model_i.write_reg(8'h02, 8'(s));
      cyc(1);
      chk({8'h00, slope_code}, 10'(s), "slope code");
      chk({2'h0, slope_vus}, slope_tab[s], "slope");
    end
    // code 7 stays unwritten, the host may not use it
    for (int m = 0; m < 7; m++) begin
      stpcfg_host_model_i.write_reg(8'h01, {3'(m), 5'h00});
      cyc(1);
      chk({7'h00, step_res}, 10'(m), "step mode");
      chk({9'h000, code_rsv}, 10'h000, "reserved flag");
    end
    $display("test decode done");
    set_in(13'h1400, 7'h00);
    rd(8'h04, par(7'h48));
    set_in(13'h0A00, 7'h00);
    rd(8'h04, par(7'h24));
    set_in(13'h00E0, 7'h00);
    set_in(13'h0000, 7'h00);
    rd(8'h04, 8'h00);
    rd(8'h05, par(7'h70));
    rd(8'h05, 8'h00);
    set_in(13'h0108, 7'h00);
    set_in(13'h0000, 7'h55);
    rd(8'h06, par(7'h44));
    rd(8'h06, 8'h00);
    rd(8'h07, par(7'h55));
    set_in(13'h0000, 7'h01);
    rd(8'h07, par(7'h01));
    $display("test status done");
    for (int p = 0; p < 2; p++) begin
      stpcfg_host_model_i.write_reg(8'h02, {1'b0, p[0], 6'h00});
      cyc(1);
      chk({9'h000, step_pol}, 10'(p), "polarity");
      hi = 0;
      lo = 0;
      for (int k = 0; k < 12; k++) begin
        @(posedge clk) step_in <= (k % 6) < 3;
        @(negedge clk);
        if (step_adv === 1'b1) begin
          if (step_in) hi++;
          else lo++;
        end
      end
      chk(10'(hi), p ? 10'h000 : 10'h002, "rise steps");
      chk(10'(lo), p ? 10'h002 : 10'h000, "fall steps");
    end
    $display("test step edge done");
    finish_test();
  end
  // whole run needs about 250 cycles
  initial begin
    #200000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : stpcfg_core_tb_top
`default_nettype wire

// [dv/stpcfg_host_model.sv]
// host-side register access model of the stepper config bank
`timescale 1ns/10ps
`default_nettype none
module stpcfg_host_model
  import stpcfg_pkg::*;
(
  // clock
  input wire logic CLK,
  // register port
  output stpcfg_req_t REG_REQ,
  input wire logic [7:0] RD_DATA,
  input wire logic RD_VALID
);
  initial REG_REQ = '0;
  // idle fields flip so a stale address is never held
  task automatic idle();
    REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~REG_REQ.addr, wdata: ~REG_REQ.wdata};
  endtask : idle
  // step code 7 is never sent by callers
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    REG_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge CLK);
    idle();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v, output logic ok);
    @(posedge CLK);
    REG_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge CLK);
    idle();
    @(posedge CLK);
    ok = RD_VALID;
    v = RD_DATA;
  endtask : read_reg
endmodule : stpcfg_host_model
`default_nettype wire

// [rtl/stpcfg_core.sv]
// stepper driver configuration decode and status register bank
`timescale 1ns/10ps
`default_nettype none
`include "stpcfg_regs.svh"

// Function
// [R1] polarity bit 0 rising, 1 falling step
// [R2] current code maps monotonic 15 to 800 mA
// [R3] slope code gives 150/100/50/25 V/us
// [R4] step code decode; code 7 reserved
// [R5] four read-only status registers, reset zero
// [R6] parity bit in status bit 7
// [R7] 04h live health flags
// [R8] 05h latched X bridge over-current flags
// [R9] 06h latched Y over-current plus shutdown
// [R10] 07h live translator position
// [R11] control registers read/write, reset zero
// [R12] parity is even over seven bits
// [R13] latch holds until read and clear
module stpcfg_core
  import stpcfg_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // register access from the serial engine
  input wire stpcfg_req_t REG_REQ,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  // live conditions from the power stage and translator
  input wire stpcfg_fault_t FAULT_IN,
  input wire logic [6:0] TRANSLATOR_POSITION,
  input wire logic STEP_PULSE_INPUT,
  // step advance pulse and decoded settings
  output logic STEP_ADVANCE,
  output logic STEP_POLARITY,
  output logic [4:0] COIL_CURRENT_CODE,
  output logic [9:0] PEAK_COIL_CURRENT,
  output logic [1:0] SLOPE_CODE,
  output logic [7:0] SLOPE_VUS,
  output stpcfg_mode_t STEP_RESOLUTION,
  output logic STEP_CODE_RESERVED
);

  localparam logic [9:0] PEAK_TABLE [32] = '{
    `STPCFG_PEAK_MIN, 10'h01E, 10'h02D, 10'h032, 10'h037, 10'h03D, 10'h043, 10'h04A,
    10'h052, 10'h05B, 10'h064, 10'h06E, 10'h07A, 10'h087, 10'h095, 10'h0A4,
    10'h0B5, 10'h0C8, 10'h0DD, 10'h0F4, 10'h10D, 10'h129, 10'h148, 10'h16A,
    10'h190, 10'h1B9, 10'h1E7, 10'h21A, 10'h252, 10'h290, 10'h2D4, `STPCFG_PEAK_MAX
  };

  logic [7:0] ctl_mode_cur;
  logic [7:0] ctl_drive;
  logic [6:0] health;
  stpcfg_ovc_t ovc_x;
  stpcfg_ovc_t ovc_y;
  logic thermal_shutdown_flag;
  logic [6:0] position;
  logic step_prev;
  logic [7:0] next_rd;
  logic [6:0] low_x;
  logic [6:0] low_y;
  logic rd_x;
  logic rd_y;

  assign low_x = {ovc_x, 3'h0};
  assign low_y = {ovc_y, thermal_shutdown_flag, 2'h0};
  assign rd_x = REG_REQ.rd && (REG_REQ.addr == `STPCFG_OFS_OVC_X);
  assign rd_y = REG_REQ.rd && (REG_REQ.addr == `STPCFG_OFS_OVC_Y);

  // control registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctl_mode_cur <= `STPCFG_CTL_RESET; // [R11]
      ctl_drive <= `STPCFG_CTL_RESET; // [R11]
    end else if (REG_REQ.wr) begin
      if (REG_REQ.addr == `STPCFG_OFS_MODE_CUR) begin
        ctl_mode_cur <= REG_REQ.wdata; // [R11]
      end
      if (REG_REQ.addr == `STPCFG_OFS_DRIVE) begin
        ctl_drive <= REG_REQ.wdata; // [R11]
      end
    end
  end

  assign STEP_POLARITY = ctl_drive[`STPCFG_POL_BIT];
  assign COIL_CURRENT_CODE = ctl_mode_cur[`STPCFG_CUR_MSB:`STPCFG_CUR_LSB];
  assign SLOPE_CODE = ctl_drive[`STPCFG_SLOPE_MSB:`STPCFG_SLOPE_LSB];

  // decoded settings, registered one cycle behind the control bits
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PEAK_COIL_CURRENT <= `STPCFG_PEAK_MIN;
      SLOPE_VUS <= `STPCFG_SLOPE_C0;
      STEP_RESOLUTION <= STPCFG_RES_32;
      STEP_CODE_RESERVED <= 1'b0;
    end else begin
      PEAK_COIL_CURRENT <= PEAK_TABLE[COIL_CURRENT_CODE]; // [R2]
      unique case (SLOPE_CODE)
        2'h0: SLOPE_VUS <= `STPCFG_SLOPE_C0; // [R3]
        2'h1: SLOPE_VUS <= `STPCFG_SLOPE_C1; // [R3]
        2'h2: SLOPE_VUS <= `STPCFG_SLOPE_C2; // [R3]
        2'h3: SLOPE_VUS <= `STPCFG_SLOPE_C3; // [R3]
      endcase
      // code 7 is flagged and still driven onto STEP_RESOLUTION as STPCFG_RESERVED
      STEP_RESOLUTION <= stpcfg_mode_t'(ctl_mode_cur[`STPCFG_SM_MSB:`STPCFG_SM_LSB]); // [R4]
      STEP_CODE_RESERVED <= (ctl_mode_cur[`STPCFG_SM_MSB:`STPCFG_SM_LSB] == 3'h7); // [R4]
    end
  end

  // step edge detect; input already synchronous to CLK
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      step_prev <= 1'b0;
      STEP_ADVANCE <= 1'b0;
    end else begin
      step_prev <= STEP_PULSE_INPUT;
      STEP_ADVANCE <= STEP_POLARITY ? (step_prev && !STEP_PULSE_INPUT) // [R1]
                                    : (!step_prev && STEP_PULSE_INPUT); // [R1]
    end
  end

  // live status, sampled every cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      health <= 7'h00; // [R5]
      position <= 7'h00; // [R5]
    end else begin
      health <= {FAULT_IN.thermal_warning, FAULT_IN.charge_pump_fail, 1'b0,
                 FAULT_IN.open_coil_x, FAULT_IN.open_coil_y, 2'h0}; // [R7]
      position <= TRANSLATOR_POSITION; // [R10]
    end
  end

  // sticky faults; a condition present at the read keeps the flag set
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ovc_x <= '0; // [R5]
      ovc_y <= '0; // [R5]
      thermal_shutdown_flag <= 1'b0; // [R5]
    end else begin
      ovc_x <= FAULT_IN.ovc_x | (ovc_x & {4{!rd_x}}); // [R8] [R13]
      ovc_y <= FAULT_IN.ovc_y | (ovc_y & {4{!rd_y}}); // [R9] [R13]
      thermal_shutdown_flag <= FAULT_IN.thermal_shutdown | (thermal_shutdown_flag && !rd_y); // [R9] [R13]
    end
  end

  // read mux; unmapped and write-only-in-scope offsets read zero
  always_comb begin
    next_rd = 8'h00;
    unique case (REG_REQ.addr)
      `STPCFG_OFS_MODE_CUR: next_rd = ctl_mode_cur; // [R11]
      `STPCFG_OFS_DRIVE: next_rd = ctl_drive; // [R11]
      `STPCFG_OFS_HEALTH: next_rd = {^health, health}; // [R6] [R7] [R12]
      `STPCFG_OFS_OVC_X: next_rd = {^low_x, low_x}; // [R6] [R8] [R12]
      `STPCFG_OFS_OVC_Y: next_rd = {^low_y, low_y}; // [R6] [R9] [R12]
      `STPCFG_OFS_POSITION: next_rd = {^position, position}; // [R6] [R10] [R12]
      default: next_rd = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RD_DATA <= `STPCFG_STAT_RESET;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= REG_REQ.rd;
      // data holds between reads so a slow shifter can sample late
      if (REG_REQ.rd) begin
        RD_DATA <= next_rd;
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_rise_step: assert property (!STEP_POLARITY && !step_prev && STEP_PULSE_INPUT |=> STEP_ADVANCE) // [R1]
    else $error("rising step edge not taken");
  a_fall_step: assert property (STEP_POLARITY && step_prev && !STEP_PULSE_INPUT |=> STEP_ADVANCE) // [R1]
    else $error("falling step edge not taken");
  a_no_wrong_edge: assert property (STEP_POLARITY && !step_prev && STEP_PULSE_INPUT |=> !STEP_ADVANCE) // [R1]
    else $error("step taken on wrong edge");
  a_peak_ends: assert property ($stable(COIL_CURRENT_CODE) && COIL_CURRENT_CODE == 5'h1F |=> // [R2]
      PEAK_COIL_CURRENT == `STPCFG_PEAK_MAX)
    else $error("top current code not 800 mA");
  a_peak_monotone: assert property (COIL_CURRENT_CODE > $past(COIL_CURRENT_CODE) |=> // [R2]
      PEAK_COIL_CURRENT > $past(PEAK_COIL_CURRENT))
    else $error("peak current not monotonic");
  a_slope_slow: assert property (SLOPE_CODE == 2'h3 |=> SLOPE_VUS == `STPCFG_SLOPE_C3) // [R3]
    else $error("slope code 3 not 25 V/us");
  a_mode_reserved: assert property (ctl_mode_cur[`STPCFG_SM_MSB:`STPCFG_SM_LSB] == 3'h7 |=> STEP_CODE_RESERVED) // [R4]
    else $error("reserved step code not flagged");
  a_status_parity: assert property (RD_VALID && $past(REG_REQ.addr) >= `STPCFG_OFS_HEALTH && // [R12]
      $past(REG_REQ.addr) <= `STPCFG_OFS_POSITION |-> ^RD_DATA == 1'b0)
    else $error("status parity not even");
  a_health_live: assert property (REG_REQ.rd && REG_REQ.addr == `STPCFG_OFS_HEALTH |=> // [R7]
      RD_DATA[6] == $past(FAULT_IN.thermal_warning, 2))
    else $error("thermal warning not live");
  a_ovc_hold: assert property (ovc_x.pos_top && !rd_x |=> ovc_x.pos_top [*1]) // [R13]
    else $error("latched fault lost without read");
  a_ovc_clear: assert property (rd_y && !FAULT_IN.ovc_y.neg_bottom |=> !ovc_y.neg_bottom) // [R13]
    else $error("latched fault not cleared by read");
  a_pos_live: assert property (REG_REQ.rd && REG_REQ.addr == `STPCFG_OFS_POSITION |=> // [R10]
      RD_DATA[6:0] == $past(TRANSLATOR_POSITION, 2))
    else $error("position not live");
  a_ctl_write: assert property (REG_REQ.wr && REG_REQ.addr == `STPCFG_OFS_MODE_CUR |=> // [R11]
      ctl_mode_cur == $past(REG_REQ.wdata))
    else $error("control write not stored");
  a_no_wrong_fall: assert property (!STEP_POLARITY && step_prev && !STEP_PULSE_INPUT |=> !STEP_ADVANCE) // [R1]
    else $error("falling step taken in rising mode");
  a_peak_floor: assert property (COIL_CURRENT_CODE == 5'h00 |=> PEAK_COIL_CURRENT == `STPCFG_PEAK_MIN) // [R2]
    else $error("bottom current code not 15 mA");
  a_slope_fast: assert property (SLOPE_CODE == 2'h0 |=> SLOPE_VUS == `STPCFG_SLOPE_C0) // [R3]
    else $error("slope code 0 not 150 V/us");
  a_mode_legal: assert property (ctl_mode_cur[`STPCFG_SM_MSB:`STPCFG_SM_LSB] != 3'h7 |=> !STEP_CODE_RESERVED) // [R4]
    else $error("legal step code flagged reserved");
  a_tsd_hold: assert property (thermal_shutdown_flag && !rd_y |=> thermal_shutdown_flag) // [R13]
    else $error("shutdown flag lost without read");
  a_health_gap: assert property (RD_VALID && $past(REG_REQ.addr) == `STPCFG_OFS_HEALTH |-> // [R7]
      RD_DATA[4] == 1'b0 && RD_DATA[1:0] == 2'h0)
    else $error("unused health bits not zero");

endmodule : stpcfg_core
`default_nettype wire

// [rtl/stpcfg_pkg.sv]
// types shared by the stepper config/status bank
package stpcfg_pkg;
  typedef enum logic [2:0] {
    STPCFG_RES_32 = 3'h0,
    STPCFG_RES_16 = 3'h1,
    STPCFG_RES_8 = 3'h2,
    STPCFG_RES_4 = 3'h3,
    STPCFG_HALF_UNCOMP = 3'h4,
    STPCFG_HALF_COMP = 3'h5,
    STPCFG_FULL = 3'h6,
    STPCFG_RESERVED = 3'h7
  } stpcfg_mode_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } stpcfg_req_t;
  typedef struct packed {
    logic pos_top;
    logic pos_bottom;
    logic neg_top;
    logic neg_bottom;
  } stpcfg_ovc_t;
  typedef struct packed {
    logic thermal_warning;
    logic charge_pump_fail;
    logic open_coil_x;
    logic open_coil_y;
    logic thermal_shutdown;
    stpcfg_ovc_t ovc_x;
    stpcfg_ovc_t ovc_y;
  } stpcfg_fault_t;
endpackage : stpcfg_pkg

// [rtl/stpcfg_regs.svh]
// register offsets, field positions and decode constants of the stepper config/status bank
`ifndef STPCFG_REGS_SVH
`define STPCFG_REGS_SVH
`define STPCFG_OFS_MODE_CUR 8'h01
`define STPCFG_OFS_DRIVE 8'h02
`define STPCFG_OFS_HEALTH 8'h04
`define STPCFG_OFS_OVC_X 8'h05
`define STPCFG_OFS_OVC_Y 8'h06
`define STPCFG_OFS_POSITION 8'h07
`define STPCFG_CTL_RESET 8'h00
`define STPCFG_STAT_RESET 8'h00
`define STPCFG_CUR_LSB 0
`define STPCFG_CUR_MSB 4
`define STPCFG_SM_LSB 5
`define STPCFG_SM_MSB 7
`define STPCFG_SLOPE_LSB 0
`define STPCFG_SLOPE_MSB 1
`define STPCFG_POL_BIT 6
`define STPCFG_PAR_BIT 7
`define STPCFG_SLOPE_C0 8'h96
`define STPCFG_SLOPE_C1 8'h64
`define STPCFG_SLOPE_C2 8'h32
`define STPCFG_SLOPE_C3 8'h19
`define STPCFG_PEAK_MIN 10'h00F
`define STPCFG_PEAK_MAX 10'h320
`endif
